// ---- adc_ctrl_pkg.sv ----
// adc_ctrl_pkg: register map, field layout and timing constants
// assumes a 32-bit apb slave on mclk at 250 mhz
package adc_ctrl_pkg;
  localparam logic [11:0] mode_off       = 12'h000;
  localparam logic [11:0] chan_off       = 12'h004;
  localparam logic [11:0] pincfg_off     = 12'h008;
  localparam logic [11:0] portdir_off    = 12'h00C;
  localparam logic [11:0] portdata_off   = 12'h010;
  localparam logic [11:0] regctl_off     = 12'h014;
  localparam logic [11:0] clkstat_off    = 12'h018;
  localparam logic [11:0] status_off     = 12'h01C;
  localparam int          run_bit        = 7;
  localparam int          cmp_en_bit     = 0;
  localparam int          rate_msb       = 5;
  localparam int          rate_lsb       = 1;
  localparam int          chan_msb       = 2;
  localparam int          osc_stop_bit   = 0;
  localparam logic [7:0]  mode_rst       = 8'h00;
  localparam logic [7:0]  chan_mask      = 8'h87;
  localparam logic [4:0]  all_dig_a      = 5'b0_1000;
  localparam logic [4:0]  all_dig_b      = 5'b1_0000;
  localparam logic [7:0]  low_current    = 8'h5A;
  localparam logic [7:0]  dir_rst        = 8'hFF;
  localparam int          settle_ns      = 1000;
  localparam int          clk_mhz        = 250;
  localparam int          settle_cyc     = (settle_ns * clk_mhz + 999) / 1000;
  localparam int          rate_cnt_w     = 8;
endpackage

// ---- adc_ctrl.sv ----
// adc_ctrl: converter mode, channel, pin-function and sensor gating
// assumes an apb master on mclk and pins synchronised here
//
// Summary of operation
// R1: software writes zero to channel register bits three to six.
// R2: software sets a pin to input before converting it.
// R3: software never selects a channel assigned as digital pin.
// R4: field codes 01000 and 10000 make all eight pins digital.
// R5: analog pins grow downward from channel seven toward channel zero.
// R6: analog-configured pin reads zero in port data.
// R7: software keeps comparator enable to start at least one microsecond.
// R8: comparator enable may occur anywhere between steps three and five.
// R9: rate fields set only the sample-to-end span, not setup time.
// R10: sensor unavailable in low-current mode or with fast oscillator stopped.
// R11: sensor works whenever fast oscillator runs, whatever clock is selected; here sensor_on also needs comparator enable.
// R12: sensor ignores pin configuration, direction and data settings.
// R13: software keeps converter clock within 0.6 to 1.8 mhz for sensor; the rate field here gives only 7.8125 to 250 mhz.
// R14: software stops conversion before changing rate or level fields.
// R15: mode bit seven starts conversion, bit zero enables comparator.
// R16: start waits the stabilisation interval after comparator enable.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  shared_pin_in,
  input  wire logic        sensor_select,
  output logic      [7:0]  analog_pin_en,
  output logic      [2:0]  active_channel,
  output logic             comparator_on,
  output logic             converting,
  output logic             sample_phase,
  output logic             adc_clk_en,
  output logic             sensor_on
);
  logic [7:0] converter_mode_reg_r;
  logic [7:0] channel_select_reg_r;
  logic [4:0] pin_function_config_reg_r;
  logic [7:0] analog_port_direction_reg_r;
  logic [7:0] analog_port_data_reg_r;
  logic [7:0] regulator_control_reg_r;
  logic [7:0] clock_status_control_reg_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic [15:0] settle_cnt_r;
  logic        settled_r;
  logic [rate_cnt_w-1:0] div_cnt_r;
  logic [rate_cnt_w-1:0] div_top;
  logic [7:0]  analog_mask;
  logic [7:0]  port_read;
  logic        wr_en;
  logic        rd_ok;
  logic        sensor_ok;

  // ****************************************
  // apb slave
  // ****************************************
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  always_comb begin
    rd_ok   = 1'b1;
    prdata  = 32'h0000_0000;
    unique case (paddr)
      mode_off:     prdata[7:0] = converter_mode_reg_r;
      chan_off:     prdata[7:0] = channel_select_reg_r;
      pincfg_off:   prdata[4:0] = pin_function_config_reg_r;
      portdir_off:  prdata[7:0] = analog_port_direction_reg_r;
      portdata_off: prdata[7:0] = port_read;
      regctl_off:   prdata[7:0] = regulator_control_reg_r;
      clkstat_off:  prdata[7:0] = clock_status_control_reg_r;
      status_off:   prdata[3:0] = {sensor_ok, settled_r, converting,
                                   comparator_on};
      default:      rd_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_ok;

  // ****************************************
  // register writes, one block per register
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      converter_mode_reg_r <= mode_rst;
    end else if (wr_en && paddr == mode_off) begin
      converter_mode_reg_r <= pwdata[7:0];
    end
  end

  // reserved bits are kept at zero in hardware as well [R1]
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      channel_select_reg_r <= 8'h00;
    end else if (wr_en && paddr == chan_off) begin
      channel_select_reg_r <= pwdata[7:0] & chan_mask;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_function_config_reg_r <= 5'h00;
    end else if (wr_en && paddr == pincfg_off) begin
      pin_function_config_reg_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      analog_port_direction_reg_r <= dir_rst;
    end else if (wr_en && paddr == portdir_off) begin
      analog_port_direction_reg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      analog_port_data_reg_r <= 8'h00;
    end else if (wr_en && paddr == portdata_off) begin
      analog_port_data_reg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regulator_control_reg_r <= 8'h00;
    end else if (wr_en && paddr == regctl_off) begin
      regulator_control_reg_r <= pwdata[7:0];
    end
  end

  // status is read-only: a write to it falls through every block
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clock_status_control_reg_r <= 8'h00;
    end else if (wr_en && paddr == clkstat_off) begin
      clock_status_control_reg_r <= pwdata[7:0];
    end
  end

  // ****************************************
  // pin function decode
  // ****************************************
  // field value n makes channels 0..n-1 digital; n..7 stay analog, so
  // channel seven is the last to give up its analog role
  // codes from eight upward leave no pin analog
  always_comb begin
    analog_mask = 8'h00;
    if (pin_function_config_reg_r == all_dig_a ||
        pin_function_config_reg_r == all_dig_b) begin
      analog_mask = 8'h00; // [R4]
    end else if (pin_function_config_reg_r < all_dig_a) begin
      // analog count grows from channel seven downward
      analog_mask = 8'hFF << pin_function_config_reg_r[2:0]; // [R5]
    end
  end
  assign analog_pin_en = analog_mask;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= shared_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end
  // analog pins read as zero; digital outputs read their latch
  assign port_read = ~analog_mask &
                     ((analog_port_direction_reg_r & pin_sync_r) |
                      (~analog_port_direction_reg_r &
                       analog_port_data_reg_r)); // [R6]

  // ****************************************
  // enable to start sequencing
  // ****************************************
  assign comparator_on = converter_mode_reg_r[cmp_en_bit]; // [R15]
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt_r <= 16'h0000;
      settled_r    <= 1'b0;
    end else if (!comparator_on) begin
      settle_cnt_r <= 16'h0000;
      settled_r    <= 1'b0;
    end else if (settle_cnt_r < 16'(settle_cyc - 1)) begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
    end else begin
      settled_r <= 1'b1; // [R16]
    end
  end
  // start bit low stops conversion; a start held early waits the settle
  assign converting = converter_mode_reg_r[run_bit] && comparator_on &&
                      settled_r; // [R15] [R16]

  // ****************************************
  // converter clock and channel
  // ****************************************
  // rate fields time only the sampling-to-end span; setup precedes it
  assign div_top = rate_cnt_w'(converter_mode_reg_r[rate_msb:rate_lsb]);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= '0;
    end else if (!converting || div_cnt_r >= div_top) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end
  assign adc_clk_en   = converting && (div_cnt_r == div_top); // [R9]
  assign sample_phase = converting; // [R9]

  // ****************************************
  // temperature sensor gating
  // ****************************************
  // oscillator running and regulator not in low-current mode are both needed; clock source selection plays no part
  assign sensor_ok = (regulator_control_reg_r != low_current) &&
                     !clock_status_control_reg_r[osc_stop_bit]; // [R10] [R11]
  // sensor path bypasses pin configuration entirely [R12]
  assign sensor_on = sensor_select && sensor_ok && comparator_on;
  assign active_channel = channel_select_reg_r[chan_msb:0];
endmodule
`default_nettype wire

// ---- adc_ctrl_sva.sv ----
// adc_ctrl_sva: port checks for adc_ctrl, bound below
// assumes writes take effect at the psel and penable edge
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva
  import adc_ctrl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0]  analog_pin_en,
  input wire logic        comparator_on,
  input wire logic        converting,
  input wire logic        sample_phase,
  input wire logic        adc_clk_en,
  input wire logic        sensor_on
);
  // ****************
  // properties
  // ****************
  logic       wr;
  logic [8:0] on_cnt_r;
  assign wr = psel & penable & pwrite;
  // saturating count of enabled cycles, so a late start still passes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) on_cnt_r <= 9'h000;
    else if (!comparator_on) on_cnt_r <= 9'h000;
    else if (on_cnt_r != 9'h1ff) on_cnt_r <= on_cnt_r + 9'h001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_conv_needs_cmp: assert property (converting |-> comparator_on)
    else $error("converting while comparator off");
  a_settle_min: assert property ($rose(converting) |->
    on_cnt_r >= settle_cyc) else $error("start before settling");
  a_rate_idle: assert property (!converting |-> !adc_clk_en)
    else $error("rate pulse while idle");
  a_sample_span: assert property (sample_phase == converting)
    else $error("sample phase differs from converting");
  a_pin_order: assert property (((~analog_pin_en) &
    ((~analog_pin_en) + 8'h01)) == 8'h00) else $error("analog pins not top");
  a_all_digital: assert property (wr && paddr == pincfg_off &&
    (pwdata[4:0] == all_dig_a || pwdata[4:0] == all_dig_b) |=>
    analog_pin_en == 8'h00) else $error("pins not all digital");
  a_stop_run: assert property (wr && paddr == mode_off &&
    !pwdata[run_bit] |=> !converting) else $error("run clear ignored");
  a_sensor_off: assert property (wr && ((paddr == regctl_off &&
    pwdata[7:0] == low_current) || (paddr == clkstat_off &&
    pwdata[osc_stop_bit])) |-> ##2 !sensor_on) else $error("sensor on");
  c_start: cover property ($rose(converting));
  c_rate: cover property (adc_clk_en && converting);
  c_sensor: cover property (sensor_on);
endmodule
bind adc_ctrl adc_ctrl_sva adc_ctrl_sva_i (.mclk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .analog_pin_en, .comparator_on, .converting,
  .sample_phase, .adc_clk_en, .sensor_on);
`default_nettype wire

// ---- adc_ctrl_test.sv ----
// adc_ctrl_test: self-checking random bench for adc_ctrl
// assumes the package and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_test
  import adc_ctrl_pkg::*;
;
  // ****************
  // bench
  // ****************
  logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, sensor_select = 1'b0, e, pready, pslverr;
  logic        comparator_on, converting, sample_phase, adc_clk_en, sensor_on;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_0043, rd, v, prdata;
  logic [7:0]  shared_pin_in = 8'h00, analog_pin_en;
  logic [2:0]  active_channel;
  int          fails = 0, checks = 0, k, r;
  always #2 mclk = ~mclk;
  adc_ctrl adc_ctrl_i (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shared_pin_in, .sensor_select,
    .analog_pin_en, .active_channel, .comparator_on, .converting,
    .sample_phase, .adc_clk_en, .sensor_on);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // analog pins n..7 for n below 8, none from 8 upward
  function automatic logic [7:0] amask(input int n);
    return n == 0 ? 8'hff : n > 7 ? 8'h00 : 8'hff << n;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    @(posedge mclk);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("pin_en_rst", 8'hff, analog_pin_en);
    apb(1'b0, portdir_off, 0);
    chk("dir_rst", dir_rst, rd);
    for (k = 0; k < 32; k++) begin
      v = rnd();
      apb(1'b1, pincfg_off, k);
      shared_pin_in <= v[7:0];
      repeat (3) @(posedge mclk);
      chk("pin_en", amask(k), analog_pin_en);
      apb(1'b0, portdata_off, 0);
      chk("pin_data", v[7:0] & ~amask(k), rd);
    end
    $display("test pins done");
    v = rnd();
    apb(1'b1, portdir_off, 0);
    apb(1'b1, portdata_off, v);
    apb(1'b0, portdata_off, 0);
    chk("out_latch", v[7:0], rd);
    apb(1'b1, portdir_off, {24'h00_0000, dir_rst});
    apb(1'b1, pincfg_off, 0);
    repeat (3) begin
      v = rnd() & 32'h0000_0087;
      apb(1'b1, chan_off, v);
      apb(1'b0, chan_off, 0);
      chk("chan", v & chan_mask, rd);
      chk("active_chan", v[2:0], active_channel);
    end
    for (r = 0; r < 2; r++) begin
      v = r ? rnd() % 32 : 0;
      apb(1'b1, mode_off, 0);
      // second pass enables the comparator well before the start
      if (r) begin
        apb(1'b1, mode_off, 32'h0000_0001);
        repeat (settle_cyc) @(posedge mclk);
      end
      apb(1'b1, mode_off, (v << 1) | 32'h0000_0081);
      for (k = 0; k < 400 && converting !== 1'b1; k++) @(posedge mclk);
      if (r) chk("settle_late", 0, k);
      else
        chk("settle", 1, k >= settle_cyc - 3 && k <= settle_cyc + 3);
      for (k = 0; k < 40 && adc_clk_en !== 1'b1; k++) @(posedge mclk);
      @(posedge mclk);
      for (k = 1; k < 40 && adc_clk_en !== 1'b1; k++) @(posedge mclk);
      chk("rate_period", v + 1, k);
      apb(1'b1, mode_off, 32'h0000_0001);
      chk("stopped", 0, converting);
    end
    $display("test start done");
    chk("idle_conv", 0, converting);
    sensor_select <= 1'b1;
    for (k = 0; k < 4; k++) begin
      v = rnd();
      if (v[7:0] == low_current) v = 0;
      apb(1'b1, regctl_off, k[0] ? low_current : v[7:0]);
      apb(1'b1, clkstat_off, k[1]);
      repeat (2) @(posedge mclk);
      chk("sensor", k == 0, sensor_on);
    end
    apb(1'b0, 12'h020, 0);
    chk("unmapped_err", 1, e);
    chk("unmapped_rd", 0, rd);
    $display("test sensor and bus done");
    test_done();
  end
endmodule
`default_nettype wire
